// file: shared/dmacr_pkg.sv
/*
 dmacr_pkg: constants and types of the four-channel DMA request and cycle block.
 Assumes: compiled before verilog/dmacr_top.sv; nothing else.
*/
// What this block does
// - pin edges request DMA, interrupt setup untouched
// - code 0 software, 1 fall, 2 both
// - codes 18h-1Bh pick serial tx/rx requests
// - channel 3 has no pin source here
// - mode picks rx or ack; two-wire route
// - mode 00 off, 01 single, 11 repeat
// - size 00 byte, 01 half, 10 word
// - source address fixed or incrementing
// - destination address fixed or incrementing
// - reads first, then writes, cost by target
// - byte units add no bus cycles
// - half units add one when straddling
// - word units add per width and offset
// - each region own width and access count
// - program flash two same page, else three
// - ram one, two after a write
// - back-to-back peripheral accesses add one
// - external cycles wait for ready when mem_exp_mode set
// - ram and peripheral costs depend on the access before it, flash on the last read
// - length reads plus writes plus one
// - channel 0 first; cpu slot between
// - pending requests are not counted
`default_nettype none
package dmacr_pkg;
	localparam int         NCH         = 4;
	localparam logic [1:0] MODE_OFF    = 2'h0;
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	localparam logic [1:0] MODE_REPEAT = 2'h3;
	localparam logic [1:0] SZ_16       = 2'h1;
	localparam logic [1:0] SZ_32       = 2'h2;
	localparam logic [1:0] BW_8        = 2'h0;
	localparam logic [1:0] BW_16       = 2'h1;
	localparam logic [1:0] BW_32       = 2'h2;
	localparam logic [1:0] BW_64       = 2'h3;
	localparam logic [4:0] SRC_SW      = 5'h00;
	localparam logic [4:0] SRC_FALL    = 5'h01;
	localparam logic [4:0] SRC_BOTH    = 5'h02;
	localparam logic [4:0] SRC_SER_LO  = 5'h18;
	localparam logic [4:0] SRC_SER_HI  = 5'h1b;
	localparam logic [2:0] SEL_MODE    = 3'h0;
	localparam logic [2:0] SEL_SRCSEL  = 3'h1;
	localparam logic [2:0] SEL_SRCADR  = 3'h2;
	localparam logic [2:0] SEL_DSTADR  = 3'h3;
	localparam logic [2:0] SEL_COUNT   = 3'h4;
	localparam logic [7:0] MODE_RST    = 8'h00;
	localparam logic [4:0] SRCSEL_RST  = 5'h00;
	localparam logic [31:0] SFR0_HI    = 32'h0000001f;
	localparam logic [31:0] SFR_HI     = 32'h000003ff;
	localparam logic [31:0] RAM_HI     = 32'h0003ffff;
	localparam logic [31:0] S2_LO      = 32'h00040000;
	localparam logic [31:0] S2_W32A    = 32'h00042000;
	localparam logic [31:0] S2_W32A_HI = 32'h00043fff;
	localparam logic [31:0] S2_SLOW    = 32'h000440e0;
	localparam logic [31:0] S2_SLOW_HI = 32'h000443ff;
	localparam logic [31:0] S2_W32B    = 32'h00046000;
	localparam logic [31:0] S2_SLOWB_HI= 32'h000467ff;
	localparam logic [31:0] S2_CPU     = 32'h00048000;
	localparam logic [31:0] S2_HI      = 32'h0004ffff;
	localparam logic [31:0] DF_LO      = 32'h00060000;
	localparam logic [31:0] DF_HI      = 32'h00061fff;
	localparam logic [31:0] EXT_LO     = 32'h00080000;
	localparam logic [31:0] EXT_HI     = 32'h01ffffff;
	localparam logic [31:0] EXTB_LO    = 32'hfe000000;
	localparam logic [31:0] PF_LO      = 32'hffe00000;
	localparam logic [3:0] ACC_ONE     = 4'h1;
	localparam logic [3:0] ACC_TWO     = 4'h2;
	localparam logic [3:0] ACC_THREE   = 4'h3;
	localparam logic [3:0] ACC_DF      = 4'h5;
	localparam logic [2:0] RK_CPU      = 3'h0;
	localparam logic [2:0] RK_RAM      = 3'h1;
	localparam logic [2:0] RK_PF       = 3'h2;
	localparam logic [2:0] RK_PER      = 3'h3;
	localparam logic [2:0] RK_EXT      = 3'h4;
	typedef struct packed {
		logic [1:0] rsv;
		logic       dst_incr_sel;
		logic       src_incr_sel;
		logic [1:0] unit_size;
		logic [1:0] xfer_mode;
	} dmacr_mode_t;
	typedef struct packed {
		logic [1:0] bw;
		logic [3:0] acc;
		logic [2:0] kind;
	} dmacr_region_t;
	typedef struct packed {
		logic        we;
		logic [31:0] addr;
	} dmacr_bus_t;
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_READ  = 5'h02,
		ST_WRITE = 5'h04,
		ST_DEC   = 5'h08,
		ST_GAP   = 5'h10
	} dmacr_state_t;
endpackage
`default_nettype wire

// file: verilog/dmacr_top.sv
/*
 dmacr_top: four-channel DMA request selection, channel registers and a
 transfer sequencer that costs each read and write in bus cycles; dmacr_fifo
 buffers read data. Assumes: one cpu clock, register writes from the cpu core.
*/
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// data buffer
module dmacr_fifo #(
	parameter int W = 32,
	parameter int D = 8
) (
	input  wire logic         sys_clk,   // clock
	input  wire logic         rst_n,     // sync reset
	input  wire logic         in_valid,  // push request
	output logic              in_ready,  // room left
	input  wire logic [W-1:0] in_data,   // pushed word
	output logic              out_valid, // word present
	input  wire logic         out_ready, // pop request
	output logic [W-1:0]      out_data   // head word
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem_q [D];
	logic [W-1:0]  mem_d [D];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0]   n_q, n_d;
	logic          push, pop;
	assign in_ready  = (n_q != (AW+1)'(D));
	assign out_valid = (n_q != '0);
	assign out_data  = mem_q[rp_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_ready & out_valid;
	always_comb begin
		mem_d = mem_q;
		wp_d  = wp_q;
		rp_d  = rp_q;
		if (push) begin
			mem_d[wp_q] = in_data;
			wp_d        = (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
		end
		if (pop)
			rp_d = (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
		n_d = n_q + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge sys_clk) begin
		mem_q <= mem_d;
		wp_q  <= rst_n ? wp_d : '0;
		rp_q  <= rst_n ? rp_d : '0;
		n_q   <= rst_n ? n_d : '0;
	end
endmodule

// ==========================================================
// channels, request decode and sequencer
module dmacr_top #(
	parameter int PCLK_DIV = 2, // cpu clocks per peripheral clock
	parameter int PAGE_LSB = 4, // flash page holds 2**PAGE_LSB bytes
	parameter int FIFO_W   = 32,
	parameter int FIFO_D   = 8
) (
	input  wire logic            sys_clk,         // cpu clock
	input  wire logic            rst_n,           // sync reset
	input  wire logic            ldc_wr,          // register write strobe
	input  wire logic [1:0]      ldc_ch,          // channel addressed
	input  wire logic [2:0]      ldc_sel,         // register addressed
	input  wire logic [31:0]     ldc_wdata,       // write data
	output logic [31:0]          ldc_rdata,       // read data
	input  wire logic [3:0]      sw_trigger,      // software request pulses
	input  wire logic [2:0]      ext_request_pin, // request pins, ch0..2
	input  wire logic [1:0]      uart_tx_req,     // serial tx requests
	input  wire logic [1:0]      uart_rx_req,     // serial rx requests
	input  wire logic [1:0]      uart_ack_req,    // serial ack requests
	input  wire logic [1:0]      serial_irq_source_mode, // 1: ack not rx
	input  wire logic            twowire_irq_route_en,   // 1: two-wire
	input  wire logic            twowire_tx_req,  // two-wire request
	input  wire logic            twowire_rx_req,  // two-wire line request
	input  wire logic            mem_exp_mode,    // expanded or up mode
	input  wire logic            bus_rdy_n_pin,   // external ready, low
	input  wire logic [1:0]      ext_bus_width,   // external width code
	input  wire logic [3:0]      ext_bus_acc,     // external access count
	output logic                 bus_req,         // bus in use by dma
	output dmacr_pkg::dmacr_bus_t bus,            // direction and address
	output logic [31:0]          bus_wdata,       // write data
	input  wire logic [31:0]     bus_rdata,       // read data
	output logic                 cpu_slot,        // bus handed to cpu
	output logic [1:0]           act_ch           // channel in service
);
	localparam int NCH = dmacr_pkg::NCH;
	dmacr_pkg::dmacr_mode_t  mode_q [NCH];
	dmacr_pkg::dmacr_mode_t  mode_d [NCH];
	logic [4:0]              sel_q [NCH];
	logic [4:0]              sel_d [NCH];
	logic [31:0]             src_q [NCH];
	logic [31:0]             src_d [NCH];
	logic [31:0]             dst_q [NCH];
	logic [31:0]             dst_d [NCH];
	logic [31:0]             cnt_q [NCH];
	logic [31:0]             cnt_d [NCH];
	logic [NCH-1:0]          pend_q, pend_d, evt;
	dmacr_pkg::dmacr_state_t st_q, st_d;
	logic [1:0]              ch_q, ch_d;
	logic [7:0]              cyc_q, cyc_d;
	logic                    lw_q, lw_d, lp_q, lp_d;
	logic [31:0]             lpg_q, lpg_d;
	dmacr_pkg::dmacr_bus_t   bus_q, bus_d;
	logic [2:0]              p1_q, p2_q, p3_q;
	logic                    r1_q, r2_q;
	logic [3:0]              ser;
	logic                    f_in_rdy, f_out_vld, push, pop, go, is_ext;
	logic [7:0]              rcost, wcost;
	logic [2:0]              fall, rise;

	function automatic dmacr_pkg::dmacr_region_t region(input logic [31:0] a);
		dmacr_pkg::dmacr_region_t r;
		r = '{bw: dmacr_pkg::BW_64, acc: dmacr_pkg::ACC_ONE, kind: dmacr_pkg::RK_CPU};
		if (a <= dmacr_pkg::SFR_HI)
			r = '{dmacr_pkg::BW_16, (a <= dmacr_pkg::SFR0_HI) ? dmacr_pkg::ACC_THREE :
				dmacr_pkg::ACC_TWO, dmacr_pkg::RK_PER};
		else if (a <= dmacr_pkg::RAM_HI)
			r = '{dmacr_pkg::BW_64, dmacr_pkg::ACC_ONE, dmacr_pkg::RK_RAM};
		else if (a >= dmacr_pkg::S2_CPU && a <= dmacr_pkg::S2_HI)
			r = '{dmacr_pkg::BW_64, dmacr_pkg::ACC_TWO, dmacr_pkg::RK_CPU};
		else if (a >= dmacr_pkg::S2_LO && a < dmacr_pkg::S2_CPU) begin
			r = '{dmacr_pkg::BW_16, dmacr_pkg::ACC_TWO, dmacr_pkg::RK_PER};
			if ((a >= dmacr_pkg::S2_W32A && a <= dmacr_pkg::S2_W32A_HI) || a >= dmacr_pkg::S2_W32B)
				r.bw = dmacr_pkg::BW_32;
			if ((a >= dmacr_pkg::S2_SLOW && a <= dmacr_pkg::S2_SLOW_HI)
				|| (a >= dmacr_pkg::S2_W32B && a <= dmacr_pkg::S2_SLOWB_HI))
				r.acc = dmacr_pkg::ACC_THREE;
		end else if (a >= dmacr_pkg::DF_LO && a <= dmacr_pkg::DF_HI)
			r = '{dmacr_pkg::BW_64, dmacr_pkg::ACC_DF, dmacr_pkg::RK_CPU};
		else if ((a >= dmacr_pkg::EXT_LO && a <= dmacr_pkg::EXT_HI)
			|| (a >= dmacr_pkg::EXTB_LO && a < dmacr_pkg::PF_LO))
			r = '{ext_bus_width, ext_bus_acc, dmacr_pkg::RK_EXT};
		else if (a >= dmacr_pkg::PF_LO)
			r = '{dmacr_pkg::BW_64, dmacr_pkg::ACC_THREE, dmacr_pkg::RK_PF};
		return r;
	endfunction

	function automatic logic [1:0] extra(input logic [1:0] sz, input logic [1:0] bw,
		input logic [2:0] o);
		logic [1:0] x;
		x = 2'h0;
		if (sz == dmacr_pkg::SZ_16) begin
			unique case (bw)
				dmacr_pkg::BW_8:  x = 2'h1;
				dmacr_pkg::BW_16: x = {1'b0, o[0]};
				dmacr_pkg::BW_32: x = {1'b0, &o[1:0]};
				default:          x = {1'b0, &o};
			endcase
		end else if (sz == dmacr_pkg::SZ_32) begin
			unique case (bw)
				dmacr_pkg::BW_8:  x = 2'h3;
				dmacr_pkg::BW_16: x = o[0] ? 2'h2 : 2'h1;
				dmacr_pkg::BW_32: x = {1'b0, |o[1:0]};
				default:          x = {1'b0, o >= 3'h5};
			endcase
		end
		return x;
	endfunction

	function automatic logic [7:0] cost(input logic [31:0] a, input logic we,
		input logic [1:0] sz, input logic lw, input logic lp, input logic [31:0] lpg);
		dmacr_pkg::dmacr_region_t r;
		logic [7:0] bc, a1, an;
		r  = region(a);
		bc = 8'h1 + {6'h0, extra(sz, r.bw, a[2:0])};
		a1 = {4'h0, r.acc};
		an = a1;
		unique case (r.kind)
			dmacr_pkg::RK_RAM: begin
				a1 = {4'h0, lw ? dmacr_pkg::ACC_TWO : dmacr_pkg::ACC_ONE};
				an = {4'h0, we ? dmacr_pkg::ACC_TWO : dmacr_pkg::ACC_ONE};
			end
			dmacr_pkg::RK_PF: begin
				a1 = {4'h0, ((a >> PAGE_LSB) == (lpg >> PAGE_LSB)) ? dmacr_pkg::ACC_TWO :
					dmacr_pkg::ACC_THREE};
				an = {4'h0, dmacr_pkg::ACC_TWO};
			end
			dmacr_pkg::RK_PER: begin
				a1 = 8'(a1 * PCLK_DIV) + {7'h0, lp};
				an = 8'(an * PCLK_DIV) + 8'h1;
			end
			dmacr_pkg::RK_EXT: begin
				a1 = 8'(a1 * PCLK_DIV);
				an = a1;
			end
			default: ;
		endcase
		return 8'(a1 + 8'((bc - 8'h1) * an));
	endfunction

	dmacr_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.in_valid  (push),
		.in_ready  (f_in_rdy),
		.in_data   (bus_rdata),
		.out_valid (f_out_vld),
		.out_ready (pop),
		.out_data  (bus_wdata)
	);

	// ==========================================================
	// request sources
	always_comb begin
		// edges only, irq config not read
		fall = p3_q & ~p2_q;
		rise = ~p3_q & p2_q;
		ser[0] = twowire_irq_route_en ? twowire_tx_req : uart_tx_req[0];
		ser[1] = twowire_irq_route_en ? twowire_rx_req :
			(serial_irq_source_mode[0] ? uart_ack_req[0] : uart_rx_req[0]);
		ser[2] = uart_tx_req[1];
		ser[3] = serial_irq_source_mode[1] ? uart_ack_req[1] : uart_rx_req[1];
		for (int i = 0; i < NCH; i++) begin
			evt[i] = 1'b0;
			if (sel_q[i] == dmacr_pkg::SRC_SW)
				evt[i] = sw_trigger[i];
			else if (i < 3 && sel_q[i] == dmacr_pkg::SRC_FALL)
				evt[i] = fall[i % 3];
			else if (i < 3 && sel_q[i] == dmacr_pkg::SRC_BOTH)
				evt[i] = fall[i % 3] | rise[i % 3];
			else if (sel_q[i] >= dmacr_pkg::SRC_SER_LO && sel_q[i] <= dmacr_pkg::SRC_SER_HI)
				evt[i] = ser[sel_q[i][1:0]];
			evt[i] = evt[i] & (mode_q[i].xfer_mode == dmacr_pkg::MODE_SINGLE
				|| mode_q[i].xfer_mode == dmacr_pkg::MODE_REPEAT);
		end
	end

	// ==========================================================
	// sequencer and channel registers
	always_comb begin
		is_ext = (region(bus_q.addr).kind == dmacr_pkg::RK_EXT);
		go     = (cyc_q == 8'h1) && (!is_ext || !mem_exp_mode || r2_q);
		wcost  = cost(dst_q[ch_q], 1'b1, mode_q[ch_q].unit_size, 1'b0,
			region(src_q[ch_q]).kind == dmacr_pkg::RK_PER, src_q[ch_q]);
		mode_d = mode_q;
		sel_d  = sel_q;
		src_d  = src_q;
		dst_d  = dst_q;
		cnt_d  = cnt_q;
		st_d   = st_q;
		ch_d   = ch_q;
		cyc_d  = cyc_q;
		lw_d   = lw_q;
		lp_d   = lp_q;
		lpg_d  = lpg_q;
		bus_d  = bus_q;
		push   = 1'b0;
		pop    = 1'b0;
		// one flag, set wins over clear
		pend_d = pend_q | evt;
		if (ldc_wr) begin
			unique case (ldc_sel)
				dmacr_pkg::SEL_MODE:   mode_d[ldc_ch] = {2'h0, ldc_wdata[5:0]};
				dmacr_pkg::SEL_SRCSEL: sel_d[ldc_ch]  = ldc_wdata[4:0];
				dmacr_pkg::SEL_SRCADR: src_d[ldc_ch]  = ldc_wdata;
				dmacr_pkg::SEL_DSTADR: dst_d[ldc_ch]  = ldc_wdata;
				dmacr_pkg::SEL_COUNT:  cnt_d[ldc_ch]  = ldc_wdata;
				default: ;
			endcase
		end
		unique case (st_q)
			dmacr_pkg::ST_IDLE: if (|pend_q) begin
				ch_d = pend_q[0] ? 2'h0 : pend_q[1] ? 2'h1 : pend_q[2] ? 2'h2 : 2'h3;
				pend_d[ch_d] = evt[ch_d];
				st_d  = dmacr_pkg::ST_READ;
			end
			dmacr_pkg::ST_READ: if (cyc_q > 8'h1) cyc_d = cyc_q - 8'h1;
				else if (go && f_in_rdy) begin
					push  = 1'b1;
					st_d  = dmacr_pkg::ST_WRITE;
					bus_d = '{we: 1'b1, addr: dst_q[ch_q]};
					cyc_d = wcost;
					lw_d  = 1'b0;
					lp_d  = region(bus_q.addr).kind == dmacr_pkg::RK_PER;
					lpg_d = bus_q.addr;
				end
			dmacr_pkg::ST_WRITE: if (cyc_q > 8'h1) cyc_d = cyc_q - 8'h1;
				else if (go && f_out_vld) begin
					pop  = 1'b1;
					st_d = dmacr_pkg::ST_DEC;
					lw_d = 1'b1;
					lp_d = region(bus_q.addr).kind == dmacr_pkg::RK_PER;
				end
			dmacr_pkg::ST_DEC: begin
				cnt_d[ch_q] = cnt_q[ch_q] - 32'h1;
				if (mode_q[ch_q].src_incr_sel)
					src_d[ch_q] = src_q[ch_q] + (32'h1 << mode_q[ch_q].unit_size);
				if (mode_q[ch_q].dst_incr_sel)
					dst_d[ch_q] = dst_q[ch_q] + (32'h1 << mode_q[ch_q].unit_size);
				if (mode_q[ch_q].xfer_mode == dmacr_pkg::MODE_SINGLE && cnt_q[ch_q] == 32'h1)
					mode_d[ch_q].xfer_mode = dmacr_pkg::MODE_OFF;
				st_d = dmacr_pkg::ST_GAP;
			end
			default: st_d = dmacr_pkg::ST_IDLE;
		endcase
		rcost = cost(src_q[ch_d], 1'b0, mode_q[ch_d].unit_size, lw_q, lp_q, lpg_q);
		if (st_q == dmacr_pkg::ST_IDLE && |pend_q) begin
			bus_d = '{we: 1'b0, addr: src_q[ch_d]};
			cyc_d = rcost;
		end
	end

	always_ff @(posedge sys_clk) begin
		// pins idle high: no false edge after reset
		p1_q   <= rst_n ? ext_request_pin : '1;
		p2_q   <= rst_n ? p1_q : '1;
		p3_q   <= rst_n ? p2_q : '1;
		r1_q   <= rst_n ? ~bus_rdy_n_pin : 1'b0;
		r2_q   <= rst_n ? r1_q : 1'b0;
		st_q   <= rst_n ? st_d : dmacr_pkg::ST_IDLE;
		ch_q   <= rst_n ? ch_d : 2'h0;
		cyc_q  <= rst_n ? cyc_d : 8'h0;
		lw_q   <= rst_n ? lw_d : 1'b0;
		lp_q   <= rst_n ? lp_d : 1'b0;
		lpg_q  <= rst_n ? lpg_d : '0;
		bus_q  <= rst_n ? bus_d : '0;
		pend_q <= rst_n ? pend_d : '0;
		for (int i = 0; i < NCH; i++) begin
			mode_q[i] <= rst_n ? mode_d[i] : dmacr_pkg::MODE_RST;
			sel_q[i]  <= rst_n ? sel_d[i] : dmacr_pkg::SRCSEL_RST;
			src_q[i]  <= rst_n ? src_d[i] : '0;
			dst_q[i]  <= rst_n ? dst_d[i] : '0;
			cnt_q[i]  <= rst_n ? cnt_d[i] : '0;
		end
	end

	always_comb begin
		unique case (ldc_sel)
			dmacr_pkg::SEL_MODE:   ldc_rdata = {24'h0, mode_q[ldc_ch]};
			dmacr_pkg::SEL_SRCSEL: ldc_rdata = {27'h0, sel_q[ldc_ch]};
			dmacr_pkg::SEL_SRCADR: ldc_rdata = src_q[ldc_ch];
			dmacr_pkg::SEL_DSTADR: ldc_rdata = dst_q[ldc_ch];
			dmacr_pkg::SEL_COUNT:  ldc_rdata = cnt_q[ldc_ch];
			default:               ldc_rdata = 32'h0;
		endcase
	end
	assign bus_req  = (st_q == dmacr_pkg::ST_READ) || (st_q == dmacr_pkg::ST_WRITE);
	assign bus      = bus_q;
	assign cpu_slot = (st_q == dmacr_pkg::ST_GAP);
	assign act_ch   = ch_q;

	// ==========================================================
	// checks
	sequence s_tail;
		st_q == dmacr_pkg::ST_DEC ##1 st_q == dmacr_pkg::ST_GAP ##1 st_q == dmacr_pkg::ST_IDLE;
	endsequence
	property p_tail;
		@(posedge sys_clk) disable iff (!rst_n) (st_q == dmacr_pkg::ST_WRITE && pop) |=> s_tail;
	endproperty
	a_tail: assert property (p_tail) else $error("count step or cpu slot missing");
	property p_prio;
		@(posedge sys_clk) disable iff (!rst_n)
		(st_q == dmacr_pkg::ST_IDLE && pend_q[0]) |=> (ch_q == 2'h0 && st_q == dmacr_pkg::ST_READ);
	endproperty
	a_prio: assert property (p_prio) else $error("channel 0 not served first");
	property p_gap;
		@(posedge sys_clk) disable iff (!rst_n) cpu_slot |-> !bus_req ##1 !bus_req;
	endproperty
	a_gap: assert property (p_gap) else $error("bus not left to cpu");
	property p_rsv;
		@(posedge sys_clk) disable iff (!rst_n)
		((sel_q[0] > dmacr_pkg::SRC_BOTH && sel_q[0] < dmacr_pkg::SRC_SER_LO)
		|| sel_q[0] > dmacr_pkg::SRC_SER_HI) |-> !evt[0];
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved code raised request");
	property p_rsv3;
		@(posedge sys_clk) disable iff (!rst_n)
		(sel_q[3] == dmacr_pkg::SRC_FALL || sel_q[3] == dmacr_pkg::SRC_BOTH) |-> !evt[3];
	endproperty
	a_rsv3: assert property (p_rsv3) else $error("channel 3 pin code raised request");
	property p_off;
		@(posedge sys_clk) disable iff (!rst_n)
		(mode_q[1].xfer_mode == dmacr_pkg::MODE_OFF && !pend_q[1] && !ldc_wr) |=> !pend_q[1];
	endproperty
	a_off: assert property (p_off) else $error("disabled channel went pending");
	property p_load;
		@(posedge sys_clk) disable iff (!rst_n)
		(st_q == dmacr_pkg::ST_READ && cyc_q == 8'h1 && go && f_in_rdy)
		|=> (st_q == dmacr_pkg::ST_WRITE && cyc_q == $past(wcost) && bus_q.we);
	endproperty
	a_load: assert property (p_load) else $error("write phase cost not loaded");
	property p_rdy;
		@(posedge sys_clk) disable iff (!rst_n)
		(bus_req && cyc_q == 8'h1 && is_ext && mem_exp_mode && !r2_q) |=> $stable(st_q);
	endproperty
	a_rdy: assert property (p_rdy) else $error("external cycle ended without ready");
	property p_single;
		@(posedge sys_clk) disable iff (!rst_n)
		(st_q == dmacr_pkg::ST_DEC && cnt_q[ch_q] == 32'h1 && !ldc_wr
		&& mode_q[ch_q].xfer_mode == dmacr_pkg::MODE_SINGLE)
		|=> mode_q[$past(ch_q)].xfer_mode == dmacr_pkg::MODE_OFF;
	endproperty
	a_single: assert property (p_single) else $error("single mode not stopped");
	property p_incr;
		@(posedge sys_clk) disable iff (!rst_n)
		(st_q == dmacr_pkg::ST_DEC && mode_q[ch_q].src_incr_sel && !ldc_wr)
		|=> src_q[ch_q] == $past(src_q[ch_q]) + (32'h1 << $past(mode_q[ch_q].unit_size));
	endproperty
	a_incr: assert property (p_incr) else $error("source address not stepped");
endmodule
`default_nettype wire

// file: dv/dmacr_mem_model.sv
/* dmacr_mem_model: far side of the dma bus, memory and external device.
 Assumes: bus from dmacr_top; slow holds external ready off for a while. */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// memory responder
module dmacr_mem_model (
	input  wire logic                  sys_clk,      // clock
	input  wire logic                  bus_req,      // dma owns bus
	input  wire dmacr_pkg::dmacr_bus_t bus,          // direction and address
	input  wire logic                  slow,         // stretch cycles
	output logic [31:0]                bus_rdata,    // read data
	output logic                       bus_rdy_n_pin // ready, low
);
	logic [3:0]  wait_q = 4'h0;
	logic [31:0] last_q = 32'h0;
	// data from address, toggles when not read
	assign bus_rdata = (bus_req && !bus.we) ? {~bus.addr[15:0], bus.addr[15:0]} : ~last_q;
	assign bus_rdy_n_pin = slow && (wait_q < 4'h6);
	always_ff @(posedge sys_clk) begin
		wait_q <= bus_req ? ((wait_q == 4'hf) ? wait_q : wait_q + 4'h1) : 4'h0;
		last_q <= bus_rdata;
	end
endmodule
`default_nettype wire

// file: dv/dmacr_top_tb.sv
/* dmacr_top_tb: registers, request sources, cycle costs, priority, fifo.
 Assumes: dmacr_mem_model answers the bus; request pins idle high. */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// bench
module dmacr_top_tb;
	logic        sys_clk = 1'b0, rst_n = 1'b0, ldc_wr = 1'b0, slow = 1'b0, mem_exp_mode = 1'b0;
	logic        twowire_irq_route_en = 1'b0, bus_req, cpu_slot, bus_rdy_n_pin;
	logic [1:0]  ldc_ch = 2'h0, serial_irq_source_mode = 2'h0, act_ch;
	logic [2:0]  ldc_sel = 3'h0, ext_request_pin = 3'h7;
	logic [7:0]  seq;
	logic [11:0] rq = 12'h0;
	logic [31:0] ldc_wdata = 32'h0, ldc_rdata, bus_rdata, bus_wdata, wd;
	dmacr_pkg::dmacr_bus_t bus;
	int          n_errors = 0, compares = 0, cyc = 0, len, l2, l3, k;
	logic [31:0] ts [6] = '{32'h400, 32'h407, 32'h405, 32'h400, 32'h60000, 32'h60005};
	logic [31:0] td [6] = '{32'h800, 32'h800, 32'h806, 32'h800, 32'h800, 32'h800};
	int          tz [6] = '{0, 1, 2, 2, 0, 2};
	int          te [6] = '{3, 4, 6, 3, 7, 12};
	int          rc [4] = '{3, 16, 28, 0};
	int          sb [4] = '{4, 6, 5, 7};

	dmacr_top DUT (.sys_clk, .rst_n, .ldc_wr, .ldc_ch, .ldc_sel, .ldc_wdata, .ldc_rdata,
		.sw_trigger(rq[3:0]), .ext_request_pin, .uart_tx_req(rq[5:4]), .uart_rx_req(rq[7:6]),
		.uart_ack_req(rq[9:8]), .serial_irq_source_mode, .twowire_irq_route_en,
		.twowire_tx_req(rq[10]), .twowire_rx_req(rq[11]), .mem_exp_mode, .bus_rdy_n_pin,
		.ext_bus_width(2'h2), .ext_bus_acc(4'h2), .bus_req, .bus, .bus_wdata, .bus_rdata,
		.cpu_slot, .act_ch);
	dmacr_mem_model far (.sys_clk, .bus_req, .bus, .slow, .bus_rdata, .bus_rdy_n_pin);

	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [1:0] c, input logic [2:0] s, input logic [31:0] d);
		@(negedge sys_clk);
		{ldc_wr, ldc_ch, ldc_sel, ldc_wdata} = {1'b1, c, s, d};
		@(negedge sys_clk);
		ldc_wr = 1'b0;
	endtask
	task automatic rd(input logic [1:0] c, input logic [2:0] s, input logic [31:0] e,
		input string nm);
		@(negedge sys_clk);
		{ldc_ch, ldc_sel} = {c, s};
		#1 chk(nm, ldc_rdata, e);
	endtask
	task automatic arm(input logic [1:0] c, input logic [31:0] code, input logic [31:0] md);
		wr(c, 3'h0, 32'h0);
		wr(c, 3'h1, code);
		wr(c, 3'h0, md);
	endtask
	task automatic setup(input logic [1:0] c, input logic [31:0] s, input logic [31:0] d,
		input logic [31:0] n, input logic [7:0] md);
		wr(c, 3'h2, s);
		wr(c, 3'h3, d);
		wr(c, 3'h4, n);
		wr(c, 3'h0, {24'h0, md});
	endtask
	task automatic reset_all();
		rst_n = 1'b0;
		repeat (5) @(negedge sys_clk);
		rst_n = 1'b1;
	endtask
	// one-cycle request pulse, then count finished transfers
	task automatic fire(input logic [11:0] v, input int e, input string nm);
		@(negedge sys_clk);
		rq = v;
		@(negedge sys_clk);
		{rq, k, seq} = '0;
		repeat (60) begin
			@(negedge sys_clk);
			if (cpu_slot === 1'b1) begin
				k++;
				seq = {seq[5:0], act_ch};
			end
		end
		chk(nm, k, e);
	endtask
	// cycles from first bus cycle to the cpu slot
	task automatic meas(output int n);
		n = 0;
		@(negedge sys_clk);
		rq = 12'h1;
		@(negedge sys_clk);
		rq = 12'h0;
		repeat (60) begin
			@(negedge sys_clk);
			if (bus_req === 1'b1) break;
		end
		while (cpu_slot !== 1'b1 && n < 100) begin
			if (bus_req === 1'b1 && bus.we === 1'b1) wd = bus_wdata;
			n++;
			@(negedge sys_clk);
		end
	endtask

	initial begin
		reset_all();
		rd(2'h0, 3'h0, 32'h0, "mode reset");
		rd(2'h3, 3'h1, 32'h0, "srcsel reset");
		wr(2'h1, 3'h0, 32'hff);
		rd(2'h1, 3'h0, 32'h3f, "mode bits");
		wr(2'h1, 3'h5, 32'h1234);
		rd(2'h1, 3'h5, 32'h0, "unmapped");
		for (int i = 0; i < 6; i++) begin
			reset_all();
			setup(2'h0, ts[i], td[i], 32'ha, {2'h0, i[1], i[0], tz[i][1:0], 2'h1});
			meas(len);
			chk("cycles", len, te[i]);
			if (i == 3) chk("wdata", wd, {~ts[3][15:0], ts[3][15:0]});
			rd(2'h0, 3'h2, ts[i] + (i[0] ? 32'h1 << tz[i] : 32'h0), "src");
			rd(2'h0, 3'h3, td[i] + (i[1] ? 32'h1 << tz[i] : 32'h0), "dst");
			rd(2'h0, 3'h4, 32'h9, "count");
		end
		reset_all();
		mem_exp_mode = 1'b1;
		setup(2'h0, dmacr_pkg::EXT_LO, 32'h800, 32'ha, 8'h01);
		meas(len);
		meas(len);
		slow = 1'b1;
		meas(l2);
		chk("rdy wait", 32'(l2 > len), 32'h1);
		mem_exp_mode = 1'b0;
		meas(l3);
		chk("rdy unused", l3, len);
		slow = 1'b0;
		reset_all();
		setup(2'h1, 32'h400, 32'h800, 32'ha, 8'h03);
		arm(2'h1, 32'h1, 32'h3);
		ext_request_pin[1] = 1'b0;
		fire(12'h0, 1, "fall");
		ext_request_pin[1] = 1'b1;
		fire(12'h0, 0, "rise");
		arm(2'h1, 32'h2, 32'h3);
		ext_request_pin[1] = 1'b0;
		fire(12'h0, 1, "both fall");
		ext_request_pin[1] = 1'b1;
		fire(12'h0, 1, "both rise");
		for (int i = 0; i < 4; i++) begin
			arm(2'h0, rc[i], (i == 3) ? 32'h2 : 32'h3);
			arm(2'h3, 32'h1 + {31'h0, i[0]}, 32'h3);
			fire(12'hfff, 0, "reserved");
		end
		for (int i = 0; i < 4; i++) begin
			arm(2'h2, 32'h18 + i, 32'h3);
			fire(12'hf0 & ~(12'h1 << sb[i]), 0, "other serial");
			fire(12'h1 << sb[i], 1, "serial");
		end
		serial_irq_source_mode = 2'h2;
		fire(12'h080, 0, "rx off");
		fire(12'h200, 1, "ack");
		twowire_irq_route_en = 1'b1;
		arm(2'h2, 32'h18, 32'h3);
		fire(12'h010, 0, "uart off");
		fire(12'h400, 1, "two-wire");
		reset_all();
		setup(2'h1, 32'h400, 32'h800, 32'h1, 8'h01);
		setup(2'h3, 32'h400, 32'h800, 32'h5, 8'h03);
		@(negedge sys_clk);
		rq = 12'h00a;
		@(negedge sys_clk);
		rq = 12'h008;
		fire(12'h008, 2, "one each");
		chk("order", {28'h0, seq[3:0]}, 32'h7);
		rd(2'h1, 3'h0, 32'h0, "single end");
		rd(2'h3, 3'h0, 32'h3, "repeat");
		// nine transfers wrap the read buffer pointers
		setup(2'h0, 32'h400, 32'h800, 32'h9, 8'h11);
		for (int i = 0; i < 9; i++) begin
			meas(len);
			chk("fifo data", wd, {~16'(32'h400 + i), 16'(32'h400 + i)});
		end
		rd(2'h0, 3'h2, 32'h409, "fifo src");
		rd(2'h0, 3'h4, 32'h0, "fifo count");
		rd(2'h0, 3'h0, 32'h10, "fifo single end");
		wrap_up();
	end
endmodule
`default_nettype wire
